// File: hw/sft_defines.vh
// register offsets, field positions and timing constants of the frame transmitter
`ifndef SFT_DEFINES_VH
`define SFT_DEFINES_VH
`define SFT_OFF_CSR        4'h0
`define SFT_OFF_DBUF       4'h4
`define SFT_OFF_PAR        4'h8
`define SFT_CSR_ENABLE     4
`define SFT_CSR_ABORT      0
`define SFT_CSR_ACTIVE     9
`define SFT_CSR_EMPTY      7
`define SFT_CSR_UNDERRUN   15
`define SFT_DBUF_SOM       8
`define SFT_DBUF_EOM       9
`define SFT_PAR_CRC_INH    9
`define SFT_PAR_CHAR_MODE  15
`define SFT_CRC_POLY_BIT   16'h8408
`define SFT_CRC_POLY_CHAR  16'hA001
`define SFT_FLAG           8'h7E
`define SFT_ABORT_CHAR     8'hFF
`define SFT_START_HALVES   4
`define SFT_STOP_HALVES    3
`endif

// File: hw/sft_crc.v
// sixteen-bit serial check value generator, lsb first, two polynomials
`timescale 1ns/1ps
`default_nettype none
`include "sft_defines.vh"
module sft_crc (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        init,
    input  wire        init_ones,
    input  wire        char_mode,
    input  wire        shift_en,
    input  wire        din,
    output reg  [15:0] crc_q
);
    wire        fb;
    wire [15:0] poly;
    wire [15:0] crc_d;

    assign fb    = crc_q[0] ^ din;
    assign poly  = char_mode ? `SFT_CRC_POLY_CHAR : `SFT_CRC_POLY_BIT;
    assign crc_d = {1'b0, crc_q[15:1]} ^ (fb ? poly : 16'h0000);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= 16'hFFFF;
        end else if (ce) begin
            if (init) begin
                crc_q <= init_ones ? 16'hFFFF : 16'h0000;
            end else if (shift_en) begin
                crc_q <= crc_d;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/sft_tx.v
// bit-synchronous frame transmitter with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "sft_defines.vh"
module sft_tx (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        tx_bit_clk,
    output reg         tx_data_out,
    output reg         tx_active,
    output reg         tx_buffer_empty_flag
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_RUN   = 3'd2;
    localparam ST_STOP  = 3'd3;

    localparam K_FLAG  = 3'd0;
    localparam K_DATA  = 3'd1;
    localparam K_CRCLO = 3'd2;
    localparam K_CRCHI = 3'd3;
    localparam K_ABORT = 3'd4;
    localparam K_MARK  = 3'd5;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser for modem clock
    reg        bclk_s1_q;
    reg        bclk_s2_q;
    reg        bclk_s3_q;
    wire       fall;
    wire       rise;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end else if (ce) begin
            bclk_s1_q <= tx_bit_clk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
        end
    end
    assign fall = bclk_s3_q & ~bclk_s2_q;
    assign rise = ~bclk_s3_q & bclk_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg        enable_q;
    reg        abort_req_q;
    reg        underrun_q;
    reg        crc_inh_q;
    reg        char_mode_q;
    reg [7:0]  dbuf_q;
    reg        som_q;
    reg        eom_q;
    reg        dvalid_q;
    reg        defer_q;
    reg        crc_init_req_q;

    reg [2:0]  state_q;
    reg [2:0]  kind_q;
    reg [7:0]  shreg_q;
    reg [2:0]  bitcnt_q;
    reg [2:0]  ones_q;
    reg        stuff_q;
    reg [2:0]  halves_q;
    reg        crc_en_q;

    wire [15:0] crc_val;
    wire        wr_hit;
    wire        rd_hit;
    wire        char_end;
    wire        bit_adv;
    wire        cur_bit;
    wire        crc_shift;
    wire        stuff_due;
    wire [15:0] crc_poly;
    wire [15:0] crc_fin;
    reg         load_next;
    reg  [2:0]  next_kind;
    reg  [7:0]  next_byte;
    reg         next_empty;
    reg         next_under;

    function [31:0] reg_read;
        input [3:0] addr;
        begin
            case (addr)
                `SFT_OFF_CSR:  reg_read = ({31'h0, underrun_q} << `SFT_CSR_UNDERRUN)
                                        | ({31'h0, tx_active} << `SFT_CSR_ACTIVE)
                                        | ({31'h0, tx_buffer_empty_flag} << `SFT_CSR_EMPTY)
                                        | ({31'h0, enable_q} << `SFT_CSR_ENABLE)
                                        | ({31'h0, abort_req_q} << `SFT_CSR_ABORT);
                `SFT_OFF_DBUF: reg_read = ({31'h0, eom_q} << `SFT_DBUF_EOM)
                                        | ({31'h0, som_q} << `SFT_DBUF_SOM)
                                        | {24'h0, dbuf_q};
                `SFT_OFF_PAR:  reg_read = ({31'h0, char_mode_q} << `SFT_PAR_CHAR_MODE)
                                        | ({31'h0, crc_inh_q} << `SFT_PAR_CRC_INH);
                default:       reg_read = 32'h0000_0000;
            endcase
        end
    endfunction

    // one wait cycle per access, answer on the second edge
    assign wr_hit = avs_write & ~avs_waitrequest;
    assign rd_hit = avs_read & ~avs_waitrequest;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= reg_read(avs_address);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serialiser: shift on falling edge of modem clock
    assign bit_adv  = fall & (state_q == ST_RUN);
    // a zero stuffed after the last bit ends the character one fall later
    assign stuff_due = ~char_mode_q & ~stuff_q & shreg_q[0] & (ones_q == 3'd4)
                     & (kind_q == K_DATA || kind_q == K_CRCLO || kind_q == K_CRCHI);
    assign char_end = bit_adv & ((~stuff_q & (bitcnt_q == 3'd7) & ~stuff_due)
                               | (stuff_q & (bitcnt_q == 3'd0)));
    assign cur_bit  = stuff_q ? 1'b0 : shreg_q[0];
    // stuffed zeros and non-data excluded from check value
    assign crc_shift = bit_adv & ~stuff_q & crc_en_q & ~crc_inh_q & (kind_q == K_DATA);
    // check value including the bit shifted on this very edge
    assign crc_poly  = char_mode_q ? `SFT_CRC_POLY_CHAR : `SFT_CRC_POLY_BIT;
    assign crc_fin   = crc_shift ? ({1'b0, crc_val[15:1]}
                                    ^ ((crc_val[0] ^ shreg_q[0]) ? crc_poly : 16'h0000))
                                 : crc_val;

    sft_crc u_crc (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .init      (crc_init_req_q),
        .init_ones (~char_mode_q),
        .char_mode (char_mode_q),
        .shift_en  (crc_shift),
        .din       (shreg_q[0]),
        .crc_q     (crc_val)
    );

    // choice of the next character at a character boundary
    always @* begin
        next_kind  = K_FLAG;
        next_byte  = `SFT_FLAG;
        next_empty = 1'b0;
        next_under = 1'b0;
        load_next  = 1'b0;
        if (kind_q == K_DATA && eom_q && !crc_inh_q) begin
            next_kind  = K_CRCLO;
            next_byte  = char_mode_q ? crc_fin[7:0] : ~crc_fin[7:0];
            next_empty = 1'b1;
        end else if (kind_q == K_CRCLO) begin
            next_kind = K_CRCHI;
            next_byte = char_mode_q ? crc_val[15:8] : ~crc_val[15:8];
        end else if (char_mode_q) begin
            if (dvalid_q) begin
                next_kind  = K_DATA;
                next_byte  = dbuf_q;
                next_empty = 1'b1;
                load_next  = 1'b1;
            end else begin
                next_kind  = K_MARK;
                next_byte  = 8'hFF;
                next_under = ~eom_q & ~som_q & (kind_q != K_MARK);
            end
        end else if (som_q || eom_q || kind_q == K_CRCHI) begin
            next_kind  = K_FLAG;
            next_byte  = `SFT_FLAG;
            next_empty = 1'b1;
        end else if (abort_req_q || kind_q == K_ABORT) begin
            next_kind = K_ABORT;
            next_byte = `SFT_ABORT_CHAR;
            if (dvalid_q) begin
                next_kind = K_DATA;
                next_byte = dbuf_q;
                load_next = 1'b1;
                next_empty = 1'b1;
            end
        end else if (dvalid_q) begin
            next_kind  = K_DATA;
            next_byte  = dbuf_q;
            next_empty = 1'b1;
            load_next  = 1'b1;
        end else begin
            next_kind  = K_ABORT;
            next_byte  = `SFT_ABORT_CHAR;
            next_under = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and transmit sequencing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q             <= 1'b0;
            abort_req_q          <= 1'b0;
            underrun_q           <= 1'b0;
            crc_inh_q            <= 1'b0;
            char_mode_q          <= 1'b0;
            dbuf_q               <= 8'h00;
            som_q                <= 1'b0;
            eom_q                <= 1'b0;
            dvalid_q             <= 1'b0;
            defer_q              <= 1'b0;
            crc_init_req_q       <= 1'b0;
            state_q              <= ST_IDLE;
            kind_q               <= K_MARK;
            shreg_q              <= 8'hFF;
            bitcnt_q             <= 3'd0;
            ones_q               <= 3'd0;
            stuff_q              <= 1'b0;
            halves_q             <= 3'd0;
            crc_en_q             <= 1'b0;
            tx_data_out          <= 1'b1;
            tx_active            <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
        end else if (ce) begin
            crc_init_req_q <= 1'b0;
            if (wr_hit) begin
                case (avs_address)
                    `SFT_OFF_CSR: begin
                        enable_q    <= avs_writedata[`SFT_CSR_ENABLE];
                        abort_req_q <= avs_writedata[`SFT_CSR_ABORT];
                    end
                    `SFT_OFF_DBUF: begin
                        dbuf_q               <= avs_writedata[7:0];
                        som_q                <= avs_writedata[`SFT_DBUF_SOM];
                        eom_q                <= avs_writedata[`SFT_DBUF_EOM];
                        dvalid_q             <= ~avs_writedata[`SFT_DBUF_SOM]
                                              & ~avs_writedata[`SFT_DBUF_EOM];
                        tx_buffer_empty_flag <= 1'b0;
                        if (avs_writedata[`SFT_DBUF_SOM]) begin
                            crc_init_req_q <= 1'b1;
                            underrun_q     <= 1'b0;
                            crc_en_q       <= 1'b0;
                        end
                    end
                    `SFT_OFF_PAR: begin
                        crc_inh_q   <= avs_writedata[`SFT_PAR_CRC_INH];
                        char_mode_q <= avs_writedata[`SFT_PAR_CHAR_MODE];
                    end
                    default: begin
                    end
                endcase
            end
            case (state_q)
                ST_IDLE: begin
                    tx_data_out <= 1'b1;
                    if (enable_q && som_q) begin
                        state_q  <= ST_START;
                        halves_q <= 3'd0;
                    end
                end
                ST_START: begin
                    if (rise || fall) begin
                        halves_q <= halves_q + 3'd1;
                    end
                    if (fall && halves_q >= `SFT_START_HALVES - 3'd1) begin
                        state_q  <= ST_RUN;
                        kind_q   <= char_mode_q ? K_DATA : K_FLAG;
                        tx_data_out <= char_mode_q ? dbuf_q[0] : 1'b0;
                        shreg_q  <= char_mode_q ? {1'b1, dbuf_q[7:1]} : {1'b1, 7'h3F};
                        bitcnt_q <= 3'd1;
                        ones_q   <= 3'd0;
                        stuff_q  <= 1'b0;
                        tx_active <= 1'b1;
                        if (!wr_hit) begin
                            tx_buffer_empty_flag <= 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (bit_adv) begin
                        tx_data_out <= cur_bit;
                        if (kind_q == K_DATA || kind_q == K_CRCLO || kind_q == K_CRCHI) begin
                            if (!char_mode_q && !stuff_q && shreg_q[0]) begin
                                ones_q  <= ones_q + 3'd1;
                                stuff_q <= (ones_q == 3'd4);
                            end else begin
                                ones_q  <= 3'd0;
                                stuff_q <= 1'b0;
                            end
                        end else begin
                            ones_q  <= 3'd0;
                            stuff_q <= 1'b0;
                        end
                        if (!stuff_q) begin
                            shreg_q  <= {1'b1, shreg_q[7:1]};
                            bitcnt_q <= bitcnt_q + 3'd1;
                        end
                    end
                    if (char_end) begin
                        if (!enable_q && (kind_q == K_FLAG || kind_q == K_MARK
                                          || (!som_q && !eom_q))) begin
                            state_q  <= ST_STOP;
                            halves_q <= 3'd0;
                        end else begin
                            kind_q  <= next_kind;
                            shreg_q <= next_byte;
                            bitcnt_q <= 3'd0;
                            if (kind_q == K_FLAG && next_kind == K_DATA) begin
                                crc_en_q <= 1'b1;
                            end
                            if (char_mode_q && load_next) begin
                                crc_en_q <= 1'b1;
                            end
                            if (load_next) begin
                                dvalid_q <= 1'b0;
                            end
                            if (next_under) begin
                                underrun_q <= 1'b1;
                            end
                            if (next_empty && !wr_hit) begin
                                tx_buffer_empty_flag <= 1'b1;
                            end
                        end
                        if (!enable_q && eom_q && kind_q != K_FLAG) begin
                            defer_q <= 1'b1;
                        end
                    end
                end
                ST_STOP: begin
                    // last bit stands until its closing fall, then mark
                    if (fall && halves_q >= 3'd1) begin
                        tx_data_out <= 1'b1;
                    end
                    if (rise || fall) begin
                        halves_q <= halves_q + 3'd1;
                    end
                    if (halves_q >= `SFT_STOP_HALVES + 3'd2) begin
                        state_q   <= ST_IDLE;
                        tx_active <= 1'b0;
                        crc_en_q  <= 1'b0;
                        defer_q   <= 1'b0;
                        if (defer_q && !wr_hit) begin
                            tx_buffer_empty_flag <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verif/sft_tx_asserts.sv
// port-level assertions for the frame transmitter
`timescale 1ns/1ps
`default_nettype none
module sft_tx_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_bit_clk,
    input wire logic        tx_data_out,
    input wire logic        tx_active,
    input wire logic        tx_buffer_empty_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_dbuf_taken;
        avs_write && !avs_waitrequest && avs_address == 4'h4;
    endsequence
    property p_answer;
        s_req_seen |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_rd_hold;
        $changed(avs_readdata) |-> avs_read && !avs_waitrequest;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata changed outside a read");
    property p_empty_clr;
        s_dbuf_taken |=> !tx_buffer_empty_flag;
    endproperty
    a_empty_clr: assert property (p_empty_clr) else $error("empty flag kept after write");
    property p_empty_fall;
        $fell(tx_buffer_empty_flag) |-> $past(avs_write && !avs_waitrequest && avs_address == 4'h4);
    endproperty
    a_empty_fall: assert property (p_empty_fall) else $error("empty flag fell without write");
    property p_line_on_bit;
        $changed(tx_data_out) |-> !tx_bit_clk;
    endproperty
    a_line_on_bit: assert property (p_line_on_bit) else $error("line moved off bit edge");
    property p_start_edge;
        $rose(tx_active) |-> !tx_bit_clk;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("active rose off bit edge");
    property p_empty_edge;
        $rose(tx_buffer_empty_flag) && tx_active |-> !tx_bit_clk;
    endproperty
    a_empty_edge: assert property (p_empty_edge) else $error("empty rose off bit edge");
    property p_idle_mark;
        (!tx_active) [*8] |-> tx_data_out;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not at mark");
endmodule
bind sft_tx sft_tx_asserts i_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_bit_clk(tx_bit_clk),
    .tx_data_out(tx_data_out), .tx_active(tx_active),
    .tx_buffer_empty_flag(tx_buffer_empty_flag));
`default_nettype wire

// File: verif/sft_modem_model.sv
// modem model: free-running transmit bit clock, captures the line
`timescale 1ns/1ps
`default_nettype none
module sft_modem_model (
    output logic      tx_bit_clk,
    input wire logic  tx_data_out
);
    logic rx_bits[$];
    initial begin
        tx_bit_clk = 1'b1;
        #37;
        forever #80 tx_bit_clk = ~tx_bit_clk;
    end
    // data moves on the falling edge, so sample on the rising one
    always @(posedge tx_bit_clk) rx_bits.push_back(tx_data_out);
endmodule
`default_nettype wire

// File: verif/test_sync_serial_frame_transmitter.sv
// self-checking bench for the frame transmitter
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_frame_transmitter;
    logic        clk;
    logic        rst_n;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tx_bit_clk;
    logic        tx_data_out;
    logic        tx_active;
    logic        tx_buffer_empty_flag;
    int          fail_count;
    int          cmp_count;
    int          n;
    int          base;
    int          ones;
    logic [31:0] rd;
    logic [15:0] crc;
    logic [15:0] poly;
    logic        eq[$];

    sft_tx i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_bit_clk(tx_bit_clk),
        .tx_data_out(tx_data_out), .tx_active(tx_active),
        .tx_buffer_empty_flag(tx_buffer_empty_flag));
    sft_modem_model i_modem (.tx_bit_clk(tx_bit_clk), .tx_data_out(tx_data_out));

    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic timeout(input string name);
        fail_count++;
        $display("ERROR %s expected done seen timeout", name);
        print_verdict();
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (k >= 20) timeout("bus");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_sig(ref logic s, input logic v, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (s !== v && c < 5000);
        if (c >= 5000) timeout("wait");
    endtask
    task automatic wait_bits(input int cnt);
        n = 0;
        while (i_modem.rx_bits.size() < cnt && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) timeout("bits");
    endtask
    ////////////////////////////////////////////////////////////////////
    // expected line bits, lsb first, zero after five ones when stuffing
    function automatic void put(input logic [15:0] v, input int w, input bit dat, input bit stf);
        for (int i = 0; i < w; i++) begin
            eq.push_back(v[i]);
            if (dat) crc = (crc[0] ^ v[i]) ? (crc >> 1) ^ poly : crc >> 1;
            ones = (v[i] && stf) ? ones + 1 : 0;
            if (ones == 5) begin
                eq.push_back(1'b0);
                ones = 0;
            end
        end
    endfunction
    function automatic logic [7:0] byte_at(input int i);
        logic [7:0] b;
        for (int j = 0; j < 8; j++) begin
            b[j] = (i + j < i_modem.rx_bits.size()) ? i_modem.rx_bits[i + j] : 1'bx;
        end
        return b;
    endfunction
    task automatic cmp_stream(input string name, input logic [7:0] sync);
        int i;
        int k;
        logic [63:0] sv;
        logic [63:0] ev;
        i = base;
        k = 0;
        sv = '0;
        ev = '0;
        while (i < i_modem.rx_bits.size() && i_modem.rx_bits[i] !== 1'b0) i++;
        while (sync != 8'h00 && byte_at(i) === sync && k < 8) begin
            i += 8;
            k++;
        end
        if (sync != 8'h00) check("sync count", k > 0, 1);
        foreach (eq[j]) begin
            ev[j] = eq[j];
            sv[j] = (i + j < i_modem.rx_bits.size()) ? i_modem.rx_bits[i + j] : 1'bx;
        end
        check(name, sv, ev);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        check("empty reset", tx_buffer_empty_flag, 1);
        check("line reset", tx_data_out, 1);
        bus(0, 4'h0, 32'h0);
        check("csr reset", rd & 32'h8290, 32'h80);
        bus(0, 4'hC, 32'h0);
        check("unmapped", rd, 32'h0);
        // bit mode frame with check value
        bus(1, 4'h8, 32'h0);
        bus(1, 4'h0, 32'h10);
        base = i_modem.rx_bits.size();
        bus(1, 4'h4, 32'h100);
        wait_sig(tx_active, 1'b1, n);
        check("start delay", n >= 25 && n <= 60, 1);
        check("empty at start", tx_buffer_empty_flag, 1);
        bus(1, 4'h4, 32'hFF);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h4, 32'h200);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h4, 32'h200);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h0, 32'h0);
        wait_sig(tx_active, 1'b0, n);
        eq = {};
        crc = 16'hFFFF;
        poly = 16'h8408;
        put(16'h7E, 8, 0, 0);
        put(16'hFF, 8, 1, 1);
        put(~crc, 16, 0, 1);
        put(16'h7E, 8, 0, 0);
        cmp_stream("bit frame", 8'h00);
        // repeated flags, then underrun with aborts
        bus(1, 4'h0, 32'h10);
        base = i_modem.rx_bits.size();
        bus(1, 4'h4, 32'h100);
        wait_sig(tx_active, 1'b1, n);
        wait_bits(base + 16);
        bus(1, 4'h4, 32'h81);
        n = 0;
        do begin
            bus(0, 4'h0, 32'h0);
            n++;
        end while (rd[15] !== 1'b1 && n < 300);
        check("underrun", rd[15], 1);
        wait_bits(base + 50);
        eq = {};
        put(16'h7E7E, 16, 0, 0);
        put(16'hFF81, 16, 0, 0);
        cmp_stream("abort frame", 8'h00);
        bus(1, 4'h4, 32'h100);
        bus(0, 4'h0, 32'h0);
        check("underrun clear", rd[15], 0);
        bus(1, 4'h0, 32'h0);
        wait_sig(tx_active, 1'b0, n);
        // character mode frame
        bus(1, 4'h8, 32'h8000);
        base = i_modem.rx_bits.size();
        bus(1, 4'h4, 32'h116);
        bus(1, 4'h0, 32'h10);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h4, 32'h41);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h4, 32'h200);
        wait_sig(tx_buffer_empty_flag, 1'b1, n);
        bus(1, 4'h0, 32'h0);
        wait_sig(tx_active, 1'b0, n);
        eq = {};
        crc = 16'h0000;
        poly = 16'hA001;
        put(16'h41, 8, 1, 0);
        put(crc, 16, 0, 0);
        cmp_stream("char frame", 8'h16);
        print_verdict();
    end
endmodule
`default_nettype wire
